//--- core/ais_pkg.sv
package ais_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] AIS_ENABLE_OFS   = 12'h0_000;
    localparam logic [11:0] AIS_INITIATE_OFS = 12'h0_028;
    localparam logic [11:0] AIS_SELECT_OFS   = 12'h0_040;
    localparam logic [11:0] AIS_CONTROL_OFS  = 12'h0_044;
    localparam logic [11:0] AIS_STATUS_OFS   = 12'h0_04C;

    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int          AIS_STEPS        = 8;
    localparam int          AIS_SEL_PITCH    = 4;
    localparam int          AIS_CTL_PITCH    = 4;
    localparam int          AIS_CTL_DIFF     = 0;
    localparam int          AIS_CTL_END      = 1;
    localparam int          AIS_CTL_TS       = 3;
    localparam logic [31:0] AIS_SELECT_MASK  = 32'h3333_3333;
    localparam logic [31:0] AIS_SELECT_RST   = 32'h0000_0000;
    localparam logic [31:0] AIS_CONTROL_RST  = 32'h0000_0000;
    localparam logic [2:0]  AIS_LAST_STEP    = 3'h7;
    localparam logic [2:0]  AIS_FIRST_STEP   = 3'h0;
    localparam int          AIS_ENABLE_BIT   = 0;
    localparam int          AIS_INITIATE_BIT = 0;
    localparam int          AIS_STATUS_BUSY  = 0;
    localparam int          AIS_STATUS_STEP  = 4;

    // ------------------------------------------------------------
    // Bus encodings
    // ------------------------------------------------------------
    localparam logic        AIS_HRESP_OKAY   = 1'b0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        AIS_IDLE    = 1'b0,
        AIS_CONVERT = 1'b1
    } ais_state_t;

    // One conversion request towards the converter core.
    typedef struct packed {
        logic [1:0] input_sel;
        logic       temp_sensor;
        logic       differential;
        logic [2:0] step;
    } ais_conv_t;

endpackage

//--- core/ais_seq0_input_select.sv
`timescale 1ns/1ps

// Operation
// RULE1 - One 32-bit register, eight per-step selectors
// RULE2 - Bits 29:28 route input for step eight
// RULE3 - Bits 25:24,21:20,17:16 select steps seven-five
// RULE4 - Bits 13:12,9:8,5:4,1:0 select steps four-one
// RULE5 - Gap bits read-only, writes ignored
// RULE6 - Software preserves gap bits on update
// RULE7 - Selectors clear to zero on reset
// RULE8 - Steps after last flagged step skipped
// RULE9 - Temperature flag overrides pin selection
// RULE10 - Differential step selector holds pair index
// RULE11 - Initiate while enabled starts step walk
module ais_seq0_input_select
    import ais_pkg::*;
(
    // Clock and reset.
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Converter core.
    output ais_conv_t        conv,
    output logic             conv_req,
    input  wire logic        conv_done
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [31:0] seq0_step_input_select;
    logic [31:0] seq0_step_control;
    logic        sequencer_enable_reg;
    ais_state_t  state;
    logic        dph_write;
    logic [11:0] dph_addr;
    logic        wr_en;
    logic        start_walk;
    logic        advance;
    logic        finish;
    logic        load;
    logic [2:0]  load_step;
    logic [1:0]  sel_of [AIS_STEPS];
    logic        ts_of  [AIS_STEPS];
    logic        diff_of[AIS_STEPS];
    logic        end_of [AIS_STEPS];

    // Bus never stalls and never errors.
    assign hreadyout = 1'b1;
    assign hresp     = AIS_HRESP_OKAY;

    // ------------------------------------------------------------
    // Per-step field extraction
    // ------------------------------------------------------------
    // Each step owns one nibble in both the select and control words.
    for (genvar s = 0; s < AIS_STEPS; s++) begin : g_step
        assign sel_of[s]  = seq0_step_input_select[s*AIS_SEL_PITCH +: 2]; // RULE1
        assign ts_of[s]   = seq0_step_control[s*AIS_CTL_PITCH + AIS_CTL_TS];
        assign diff_of[s] = seq0_step_control[s*AIS_CTL_PITCH + AIS_CTL_DIFF];
        assign end_of[s]  = seq0_step_control[s*AIS_CTL_PITCH + AIS_CTL_END];
    end

    // ------------------------------------------------------------
    // AHB-Lite address phase capture
    // ------------------------------------------------------------
    // Only the write intent and address are kept; the data arrives a cycle later.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            dph_write <= 1'b0;
            dph_addr  <= 12'h0_000;
        end else if (hready) begin
            dph_write <= hsel && htrans[1] && hwrite && (hsize == 3'h2);
            dph_addr  <= {haddr[11:2], 2'h0};
        end
    end

    assign wr_en = dph_write;

    // Read data is registered at the address phase so it stands in the data phase.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            case ({haddr[11:2], 2'h0})
                AIS_ENABLE_OFS:  hrdata <= {31'h0000_0000, sequencer_enable_reg};
                AIS_SELECT_OFS:  hrdata <= seq0_step_input_select;
                AIS_CONTROL_OFS: hrdata <= seq0_step_control;
                AIS_STATUS_OFS:  hrdata <= {25'h000_0000, conv.step, 3'h0, conv_req};
                default:         hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Selection register
    // ------------------------------------------------------------
    // Gap bits are masked on write so they always read back as zero.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            seq0_step_input_select <= AIS_SELECT_RST; // RULE7
        end else if (wr_en && dph_addr == AIS_SELECT_OFS) begin
            seq0_step_input_select <= hwdata & AIS_SELECT_MASK; // RULE5
        end
    end

    // ------------------------------------------------------------
    // Control and enable registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            seq0_step_control    <= AIS_CONTROL_RST;
            sequencer_enable_reg <= 1'b0;
        end else if (wr_en) begin
            if (dph_addr == AIS_CONTROL_OFS) begin
                seq0_step_control <= hwdata;
            end
            if (dph_addr == AIS_ENABLE_OFS) begin
                sequencer_enable_reg <= hwdata[AIS_ENABLE_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // Step walk control
    // ------------------------------------------------------------
    // An initiate write while busy is dropped rather than queued.
    assign start_walk = wr_en && dph_addr == AIS_INITIATE_OFS && hwdata[AIS_INITIATE_BIT]
                        && sequencer_enable_reg && state == AIS_IDLE; // RULE11
    assign finish     = state == AIS_CONVERT && conv_done
                        && (end_of[conv.step] || conv.step == AIS_LAST_STEP); // RULE8
    assign advance    = state == AIS_CONVERT && conv_done && !finish;
    assign load       = start_walk || advance;
    assign load_step  = start_walk ? AIS_FIRST_STEP : conv.step + 3'h1;

    // Disabling the sequencer aborts a walk in progress.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state <= AIS_IDLE;
        end else begin
            case (state)
                AIS_IDLE: begin
                    if (start_walk) begin
                        state <= AIS_CONVERT;
                    end
                end
                AIS_CONVERT: begin
                    if (finish || !sequencer_enable_reg) begin
                        state <= AIS_IDLE; // RULE8
                    end
                end
                default: begin
                    state <= AIS_IDLE;
                end
            endcase
        end
    end

    assign conv_req = state == AIS_CONVERT;

    // The request fields are latched per step, so a select, sensor or differential write mid-step
    // only takes effect from the next step onward; end flags and enable act at once.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            conv <= '0;
        end else if (load) begin
            conv.step         <= load_step;
            conv.input_sel    <= sel_of[load_step]; // RULE2 RULE3 RULE4
            conv.temp_sensor  <= ts_of[load_step]; // RULE9
            conv.differential <= diff_of[load_step]; // RULE10
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    sel_write_a: assert property (
        wr_en && dph_addr == AIS_SELECT_OFS |=>
            seq0_step_input_select == ($past(hwdata) & AIS_SELECT_MASK)) // RULE1
        else $error("Selection register did not take the written value.");

    gap_zero_a: assert property (
        (seq0_step_input_select & ~AIS_SELECT_MASK) == 32'h0000_0000) // RULE5
        else $error("Gap bits of the selection register are not zero.");

    step7_route_a: assert property (
        load && load_step == 3'h7 |=>
            conv.input_sel == $past(seq0_step_input_select[29:28])) // RULE2
        else $error("Step eight did not route its selector.");

    mid_route_a: assert property (
        load && load_step >= 3'h4 && load_step <= 3'h6 |=>
            conv.input_sel == $past(sel_of[load_step])) // RULE3
        else $error("Steps five to seven routed the wrong input.");

    low_route_a: assert property (
        load && load_step <= 3'h3 |=> conv.input_sel == $past(sel_of[load_step])) // RULE4
        else $error("Steps one to four routed the wrong input.");

    temp_flag_a: assert property (
        load |=> conv.temp_sensor == $past(ts_of[load_step])) // RULE9
        else $error("Temperature flag not carried to the request.");

    end_stop_a: assert property (
        conv_req && conv_done && end_of[conv.step] |=> !conv_req) // RULE8
        else $error("Walk continued past the last step.");

    step_next_a: assert property (
        advance && sequencer_enable_reg |=>
            conv_req && conv.step == $past(conv.step) + 3'h1) // RULE8
        else $error("Walk did not move to the following step.");

    walk_start_a: assert property (
        start_walk |=> conv_req && conv.step == AIS_FIRST_STEP
                       && conv.input_sel == $past(sel_of[0])) // RULE11
        else $error("Initiate did not start the walk at step one.");

    no_start_a: assert property (
        !conv_req && !sequencer_enable_reg |=> !conv_req) // RULE11
        else $error("Walk started while the sequencer was disabled.");

    reg_read_a: assert property (
        hready && hsel && htrans[1] && !hwrite && haddr == AIS_SELECT_OFS
        && !(wr_en && dph_addr == AIS_SELECT_OFS) |=>
            hrdata == $past(seq0_step_input_select)) // RULE1
        else $error("Read of the selection register returned wrong data.");

endmodule

//--- test/ais_conv_model.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Converter core stand-in
// ------------------------------------------------------------
module ais_conv_model
    import ais_pkg::*;
(
    // Clock and reset.
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    // Request side.
    input  wire logic       conv_req,
    input  wire ais_conv_t  conv,
    // Conversion time in cycles, zero answers at once.
    input  wire logic [7:0] wait_cycles,
    output logic            conv_done
);
    logic [7:0] busy_cnt;

    // One done pulse per step; a gap cycle follows so each step is seen once.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            busy_cnt  <= 8'h00;
            conv_done <= 1'b0;
        end else if (conv_req && !conv_done && busy_cnt >= wait_cycles) begin
            conv_done <= 1'b1;
            busy_cnt  <= 8'h00;
        end else begin
            conv_done <= 1'b0;
            busy_cnt  <= conv_req ? busy_cnt + 8'h01 : 8'h00;
        end
    end
endmodule

//--- test/ais_seq0_input_select_test.sv
`timescale 1ns/1ps

module ais_seq0_input_select_test
    import ais_pkg::*;
;
    logic        sys_clk, nrst, hsel, hwrite, conv_req, conv_done, hready, hresp;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, rd;
    logic [7:0]  wait_cycles;
    ais_conv_t   conv;
    ais_conv_t   seen[$];
    int          miscompares, tests_run;

    ais_seq0_input_select dut_u (.sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .conv(conv),
        .conv_req(conv_req), .conv_done(conv_done));
    ais_conv_model model_u (.sys_clk(sys_clk), .nrst(nrst), .conv_req(conv_req),
        .conv(conv), .wait_cycles(wait_cycles), .conv_done(conv_done));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // Every finished step is logged with the fields that stood during it.
    always @(posedge sys_clk) if (conv_req === 1'b1 && conv_done === 1'b1) seen.push_back(conv);

    // ------------------------------------------------------------
    // Bus and compare helpers
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Address phase held until hready, then data phase held until hready.
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1; haddr <= a; htrans <= 2'b10; hwrite <= wr; hsize <= 3'b010;
        do @(posedge sys_clk); while (hready !== 1'b1);
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
        do @(posedge sys_clk); while (hready !== 1'b1);
        rd = hrdata;
        check({31'h0, hresp}, {31'h0, AIS_HRESP_OKAY});
    endtask

    // Programs a sequence, starts it and compares every logged step.
    task automatic run_walk(input logic [31:0] sel, input logic [31:0] ctl, input int n);
        ais_conv_t e;
        int        k;
        seen.delete();
        bus(1'b1, AIS_SELECT_OFS, sel);
        bus(1'b1, AIS_CONTROL_OFS, ctl);
        bus(1'b1, AIS_ENABLE_OFS, 32'h0000_0001);
        bus(1'b1, AIS_INITIATE_OFS, 32'h0000_0001);
        for (k = 0; k < 2000 && (k < 3 || conv_req === 1'b1); k++) @(posedge sys_clk);
        // A walk still running when the limit runs out counts as a mismatch.
        check({31'h0, conv_req}, 32'h0000_0000);
        check(32'(seen.size()), 32'(n));
        for (k = 0; k < seen.size(); k++) begin
            e.input_sel    = sel[4*k +: 2];
            e.temp_sensor  = ctl[4*k + 3];
            e.differential = ctl[4*k];
            e.step         = 3'(k);
            check({25'h0, seen[k]}, {25'h0, e});
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        bus(1'b0, AIS_SELECT_OFS, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        bus(1'b0, 12'h100, 32'h0000_0000);
        check(rd, 32'h0000_0000);
    endtask

    task automatic t_gaps();
        bus(1'b1, AIS_SELECT_OFS, 32'hFFFF_FFFF);
        bus(1'b0, AIS_SELECT_OFS, 32'h0000_0000);
        check(rd, 32'h3333_3333);
    endtask

    task automatic t_full();
        wait_cycles <= 8'h00;
        run_walk(32'h1321_0321, 32'h0000_0000, 8);
    endtask

    // Differential pair index on step 0, sensor on step 1, stop after step 2.
    task automatic t_short();
        wait_cycles <= 8'h03;
        run_walk(32'h3213_0321, 32'h0000_0281, 3);
        bus(1'b0, AIS_CONTROL_OFS, 32'h0000_0000);
        check(rd, 32'h0000_0281);
    endtask

    // A slow walk is started, aborted by clearing enable, then initiate is refused.
    task automatic t_disabled();
        seen.delete();
        wait_cycles <= 8'h40;
        bus(1'b1, AIS_INITIATE_OFS, 32'h0000_0001);
        @(posedge sys_clk);
        check({31'h0, conv_req}, 32'h0000_0001);
        bus(1'b0, AIS_STATUS_OFS, 32'h0000_0000);
        check(rd, 32'h0000_0001);
        bus(1'b1, AIS_ENABLE_OFS, 32'h0000_0000);
        repeat (2) @(posedge sys_clk);
        check({31'h0, conv_req}, 32'h0000_0000);
        bus(1'b0, AIS_ENABLE_OFS, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        bus(1'b1, AIS_INITIATE_OFS, 32'h0000_0001);
        repeat (4) @(posedge sys_clk);
        check({31'h0, conv_req}, 32'h0000_0000);
        check(32'(seen.size()), 32'h0000_0000);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Whole run is under a hundred cycles; this span of 20000 cycles is far beyond it.
    initial begin
        #(50 * 20000);
        miscompares++;
        wrap_up();
    end

    initial begin
        nrst = 1'b0; hsel = 1'b0; haddr = 12'h000; htrans = 2'b00; hwrite = 1'b0;
        hsize = 3'b010; hwdata = 32'h0000_0000; wait_cycles = 8'h00;
        miscompares = 0; tests_run = 0;
        repeat (5) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        t_reset();
        t_gaps();
        t_full();
        t_short();
        t_disabled();
        wrap_up();
    end
endmodule
